// ### rtl/tap_regs.vh
`ifndef TAP_REGS_VH
`define TAP_REGS_VH
// Scan register geometry
`define TAP_IR_WIDTH 5
`define TAP_CHAIN_LEN 281
`define TAP_CHAIN_TOP 280
`define TAP_ID_WIDTH 32
// Instruction value loaded in the capture state
`define TAP_IR_CAPTURE 5'h01
// Instruction encodings
`define TAP_INSTR_EXTEST 5'h00
`define TAP_INSTR_SAMPLE 5'h01
`define TAP_INSTR_IDREAD 5'h02
`define TAP_INSTR_FLOAT 5'h03
`define TAP_INSTR_BYPASS 5'h1f
// Identification word fields
`define TAP_ID_LSB 1'b1
`define TAP_ID_VERSION 4'h0
`define TAP_ID_PART 16'h0000
`define TAP_ID_MAKER 11'h000
`endif

// ### rtl/sync_two_flop.v
`timescale 1ns/10ps
// Two-stage synchroniser for pins arriving from outside the mclk domain
module sync_two_flop #(
	parameter WIDTH = 1
) (
	input wire mclk,
	input wire reset,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta;

	// First stage feeds only the second stage
	always @(posedge mclk) begin
		if (reset) begin
			meta <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule

// ### rtl/fifo_two_entry.v
`timescale 1ns/10ps
// Two-entry buffer with valid/ready on both sides
module fifo_two_entry #(
	parameter WIDTH = 2,
	parameter DEPTH = 2
) (
	input wire mclk,
	input wire reset,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [1:0] count;
	reg rd_ptr;
	reg wr_ptr;
	wire push;
	wire pop;

	assign in_ready = (count != DEPTH);
	assign out_valid = (count != 2'd0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Pointers wrap naturally at depth two
	always @(posedge mclk) begin
		if (reset) begin
			count <= 2'd0;
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
		end else begin
			if (push) begin
				mem[wr_ptr] <= in_data;
				wr_ptr <= ~wr_ptr;
			end
			if (pop)
				rd_ptr <= ~rd_ptr;
			if (push & ~pop)
				count <= count + 2'd1;
			else if (pop & ~push)
				count <= count - 2'd1;
		end
	end
endmodule

// ### rtl/boundary_scan_tap.v
// What this block does
// - Inputs sampled on rise, output changes on fall
// - Stopped test clock at either level keeps state
// - Serial input enters top bit of active register
// - Serial output shows low bit, moves on fall
// - Five high mode-select samples force reset state
// - Test reset low forces reset state at once
// - Five-bit instruction, no parity, selects operation
// - Instruction capture loads 00001
// - Instruction shift moves toward output, top from input
// - Active instruction loaded from shift only in instruction update
// - Capture loads, shift shifts, update copies
// - Chain of 281 bits, 152 cells, 280 to 0
// - Output cells hold value and enable, one drives
// - Input cells single bit, last cell reserved
// - Sample captures all pins, bidirectional by enable
// - External test captures inputs, bidirectional as inputs
// - Data shift moves chain, top from input
// - Data update copies chain, external test drives pins
// - Chain passes bits without inversion
// - Codes: 0 ext, 1 sample, 2 id, 3 float
// - Reset state selects identification instruction
// - Bypass is one-bit stage
// - Identification word 32 bits, low bit one
`timescale 1ns/10ps
`include "tap_regs.vh"
module boundary_scan_tap #(
	parameter CHAIN_LEN = `TAP_CHAIN_LEN,
	// Bit positions holding an output or bidirectional value; its enable sits one above
	parameter [CHAIN_LEN-1:0] OUT_MASK = {CHAIN_LEN{1'b0}},
	// Bit positions of bidirectional value bits
	parameter [CHAIN_LEN-1:0] BIDIR_MASK = {CHAIN_LEN{1'b0}},
	// Bit positions of input-only cells; bit 0 is the reserved cell
	parameter [CHAIN_LEN-1:0] IN_MASK = {CHAIN_LEN{1'b0}},
	// Identification fields; values arbitrary
	parameter [3:0] ID_VERSION = `TAP_ID_VERSION,
	parameter [15:0] ID_PART = `TAP_ID_PART,
	parameter [10:0] ID_MAKER = `TAP_ID_MAKER
) (
	input wire mclk,
	input wire reset,
	input wire tck,
	input wire tms,
	input wire tdi,
	input wire trst_n,
	output reg tdo,
	output reg tdo_oe,
	input wire [CHAIN_LEN-1:0] pad_in,
	input wire [CHAIN_LEN-1:0] core_out,
	output reg [CHAIN_LEN-1:0] pad_out,
	output reg [CHAIN_LEN-1:0] pad_oe,
	output reg [4:0] tap_state,
	output reg [`TAP_IR_WIDTH-1:0] instruction_select
);
	localparam [3:0] ST_RESET = 4'h0;
	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_SEL_DR = 4'h2;
	localparam [3:0] ST_CAP_DR = 4'h3;
	localparam [3:0] ST_SH_DR = 4'h4;
	localparam [3:0] ST_EX1_DR = 4'h5;
	localparam [3:0] ST_PAU_DR = 4'h6;
	localparam [3:0] ST_EX2_DR = 4'h7;
	localparam [3:0] ST_UPD_DR = 4'h8;
	localparam [3:0] ST_SEL_IR = 4'h9;
	localparam [3:0] ST_CAP_IR = 4'ha;
	localparam [3:0] ST_SH_IR = 4'hb;
	localparam [3:0] ST_EX1_IR = 4'hc;
	localparam [3:0] ST_PAU_IR = 4'hd;
	localparam [3:0] ST_EX2_IR = 4'he;
	localparam [3:0] ST_UPD_IR = 4'hf;

	wire [2:0] pins_sync;
	reg tck_last;
	wire tck_rise;
	wire tck_fall;
	wire [1:0] smp_data;
	wire smp_valid;
	wire smp_ready;
	wire eng_ready;
	wire smp_tms;
	wire smp_tdi;
	reg [3:0] state;
	reg [3:0] next_state;
	reg [`TAP_IR_WIDTH-1:0] ir_shift;
	reg [CHAIN_LEN-1:0] pin_scan_chain;
	reg [CHAIN_LEN-1:0] chain_hold;
	reg [`TAP_ID_WIDTH-1:0] id_shift;
	reg bypass_bit;
	reg next_tdo;
	reg [CHAIN_LEN-1:0] capture_word;
	wire [`TAP_ID_WIDTH-1:0] id_word;
	wire sel_chain;
	wire sel_id;
	wire is_extest;
	wire is_float;
	wire [CHAIN_LEN-1:0] en_bits;
	wire [CHAIN_LEN-1:0] ext_oe;
	integer i;

	// Pins cross into mclk through two flops before anything reads them
	sync_two_flop #(
		.WIDTH(3)
	) u_sync (
		.mclk(mclk),
		.reset(reset),
		.async_in({tck, tms, tdi}),
		.sync_out(pins_sync)
	);

	// Test clock edges found by comparing successive synced samples
	always @(posedge mclk) begin
		if (reset)
			tck_last <= 1'b0;
		else
			tck_last <= pins_sync[2];
	end
	// A stopped test clock yields no edge, so every scan and controller register holds; pad_out still follows core_out outside extest
	assign tck_rise = pins_sync[2] & ~tck_last;
	assign tck_fall = ~pins_sync[2] & tck_last;

	// Engine stalls for a falling edge; rising samples wait in the buffer
	assign eng_ready = ~tck_fall;

	fifo_two_entry #(
		.WIDTH(2),
		.DEPTH(2)
	) u_buf (
		.mclk(mclk),
		.reset(reset),
		.in_data(pins_sync[1:0]),
		.in_valid(tck_rise),
		.in_ready(smp_ready),
		.out_data(smp_data),
		.out_valid(smp_valid),
		.out_ready(eng_ready)
	);
	// Rises are at least 16 mclk apart, so the buffer never overflows
	assign smp_tms = smp_data[1];
	assign smp_tdi = smp_data[0];

	// Standard controller transitions on each sampled mode select
	always @* begin
		next_state = state;
		case (state)
			ST_RESET: next_state = smp_tms ? ST_RESET : ST_IDLE;
			ST_IDLE: next_state = smp_tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: next_state = smp_tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: next_state = smp_tms ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: next_state = smp_tms ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: next_state = smp_tms ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: next_state = smp_tms ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: next_state = smp_tms ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: next_state = smp_tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: next_state = smp_tms ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: next_state = smp_tms ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: next_state = smp_tms ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: next_state = smp_tms ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: next_state = smp_tms ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: next_state = smp_tms ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: next_state = smp_tms ? ST_SEL_DR : ST_IDLE;
			default: next_state = ST_RESET;
		endcase
	end

	// Test reset clears the controller without waiting for any clock
	always @(posedge mclk or negedge trst_n) begin
		if (!trst_n)
			state <= ST_RESET;
		else if (reset)
			state <= ST_RESET;
		else if (smp_valid & eng_ready)
			state <= next_state;
	end

	// Register selection from the active instruction
	assign is_extest = (instruction_select == `TAP_INSTR_EXTEST);
	assign sel_chain = is_extest | (instruction_select == `TAP_INSTR_SAMPLE);
	assign sel_id = (instruction_select == `TAP_INSTR_IDREAD);
	assign is_float = (instruction_select == `TAP_INSTR_FLOAT);
	assign id_word = {ID_VERSION, ID_PART, ID_MAKER, `TAP_ID_LSB};

	// Enable bit of each value bit sits directly above it
	assign en_bits = {1'b0, core_out[CHAIN_LEN-1:1]};

	// Capture word depends on which boundary instruction is active
	always @* begin
		capture_word = pin_scan_chain;
		for (i = 0; i < CHAIN_LEN; i = i + 1) begin
			if (is_extest) begin
				if (IN_MASK[i] | BIDIR_MASK[i])
					capture_word[i] = pad_in[i];
			end else if (IN_MASK[i]) begin
				capture_word[i] = pad_in[i];
			end else if (BIDIR_MASK[i]) begin
				capture_word[i] = en_bits[i] ? core_out[i] : pad_in[i];
			end else begin
				capture_word[i] = core_out[i];
			end
		end
		if (IN_MASK[0])
			capture_word[0] = 1'b0;
	end

	// Instruction path: async reset selects identification read
	always @(posedge mclk or negedge trst_n) begin
		if (!trst_n) begin
			instruction_select <= `TAP_INSTR_IDREAD;
			ir_shift <= `TAP_IR_CAPTURE;
		end else if (reset) begin
			instruction_select <= `TAP_INSTR_IDREAD;
			ir_shift <= `TAP_IR_CAPTURE;
		end else if (smp_valid & eng_ready) begin
			case (state)
				ST_RESET: instruction_select <= `TAP_INSTR_IDREAD;
				ST_CAP_IR: ir_shift <= `TAP_IR_CAPTURE;
				ST_SH_IR: ir_shift <= {smp_tdi, ir_shift[`TAP_IR_WIDTH-1:1]};
				ST_UPD_IR: instruction_select <= ir_shift;
				default: ir_shift <= ir_shift;
			endcase
			// Load identification on the step into reset, not one test clock later
			if (next_state == ST_RESET)
				instruction_select <= `TAP_INSTR_IDREAD;
		end
	end

	// Data registers act on the rising sample, in the state they are in
	always @(posedge mclk) begin
		if (reset) begin
			pin_scan_chain <= {CHAIN_LEN{1'b0}};
			chain_hold <= {CHAIN_LEN{1'b0}};
			id_shift <= id_word;
			bypass_bit <= 1'b0;
		end else if (smp_valid & eng_ready) begin
			case (state)
				ST_CAP_DR: begin
					if (sel_chain)
						pin_scan_chain <= capture_word;
					id_shift <= id_word;
					bypass_bit <= 1'b0;
				end
				ST_SH_DR: begin
					if (sel_chain)
						pin_scan_chain <= {smp_tdi, pin_scan_chain[CHAIN_LEN-1:1]};
					if (sel_id)
						id_shift <= {smp_tdi, id_shift[`TAP_ID_WIDTH-1:1]};
					bypass_bit <= smp_tdi;
				end
				ST_UPD_DR: begin
					if (sel_chain)
						chain_hold <= pin_scan_chain;
				end
				default: bypass_bit <= bypass_bit;
			endcase
		end
	end

	// Output bit chosen from the low bit of the active register
	always @* begin
		if (state == ST_SH_IR)
			next_tdo = ir_shift[0];
		else if (sel_chain)
			next_tdo = pin_scan_chain[0];
		else if (sel_id)
			next_tdo = id_shift[0];
		else
			next_tdo = bypass_bit;
	end

	// Serial output moves only on the falling test clock edge
	always @(posedge mclk) begin
		if (reset) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else if (tck_fall) begin
			tdo <= next_tdo;
			tdo_oe <= (state == ST_SH_IR) | (state == ST_SH_DR);
		end
	end

	// Drive enables for extest: value bits follow the enable bit above
	assign ext_oe = {1'b0, chain_hold[CHAIN_LEN-1:1]} & OUT_MASK;

	// Pin drive: core in normal mode, held chain in extest, all off when floating
	always @(posedge mclk) begin
		if (reset) begin
			pad_out <= {CHAIN_LEN{1'b0}};
			pad_oe <= {CHAIN_LEN{1'b0}};
		end else if (is_float) begin
			pad_out <= core_out;
			pad_oe <= {CHAIN_LEN{1'b0}};
		end else if (is_extest) begin
			pad_out <= chain_hold;
			pad_oe <= ext_oe;
		end else begin
			pad_out <= core_out;
			pad_oe <= en_bits & OUT_MASK;
		end
	end

	// State exported for observation, one-hot free binary code
	always @(posedge mclk) begin
		if (reset)
			tap_state <= 5'h00;
		else
			tap_state <= {1'b0, state};
	end
endmodule

// ### tb/tap_monitor.sv
`timescale 1ns/10ps
module tap_monitor #(
	parameter CHAIN_LEN = 281,
	parameter [CHAIN_LEN-1:0] OUT_MASK = {CHAIN_LEN{1'b0}}
) (
	input wire mclk,
	input wire reset,
	input wire tck,
	input wire tms,
	input wire trst_n,
	input wire tdo,
	input wire tdo_oe,
	input wire [CHAIN_LEN-1:0] pad_oe,
	input wire [4:0] instruction_select
);
	reg tck_d;
	reg [2:0] hi_cnt;
	// Count rises with tms high; the raw pin is fine since tms is steady around a rise
	always @(posedge mclk) begin
		tck_d <= tck;
		if (reset || !trst_n) begin
			hi_cnt <= 3'd0;
		end else if (tck && !tck_d) begin
			hi_cnt <= !tms ? 3'd0 : (hi_cnt == 3'd5) ? 3'd5 : hi_cnt + 3'd1;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	property p_trst; !trst_n |=> instruction_select == 5'h02; endproperty
	a_trst: assert property (p_trst) else $error("test reset left instruction");
	property p_sreset; disable iff (1'b0) reset [*3] |=> instruction_select == 5'h02; endproperty
	a_sreset: assert property (p_sreset) else $error("reset left instruction");
	property p_five; hi_cnt == 3'd5 |-> ##[0:12] instruction_select == 5'h02; endproperty
	a_five: assert property (p_five) else $error("five mode rises no reset");
	property p_float; instruction_select == 5'h03 [*3] |-> pad_oe == '0; endproperty
	a_float: assert property (p_float) else $error("float left a pin driven");
	property p_oe_mask; (pad_oe & ~OUT_MASK) == '0; endproperty
	a_oe_mask: assert property (p_oe_mask) else $error("enable on non output bit");
	property p_tdo; $changed(tdo) |-> !tck && !$past(tck, 2); endproperty
	a_tdo: assert property (p_tdo) else $error("serial out moved off a fall");
	property p_tdo_oe; $changed(tdo_oe) |-> !tck && !$past(tck); endproperty
	a_tdo_oe: assert property (p_tdo_oe) else $error("out enable moved off a fall");
	property p_instr; $changed(instruction_select) |-> tck || !trst_n; endproperty
	a_instr: assert property (p_instr) else $error("instruction moved off a rise");
	c_extest: cover property (instruction_select == 5'h00 && |pad_oe);
	c_float: cover property (instruction_select == 5'h03);
	c_five: cover property (hi_cnt == 3'd5);
endmodule
bind boundary_scan_tap tap_monitor #(.CHAIN_LEN(CHAIN_LEN), .OUT_MASK(OUT_MASK)) i_mon (
	.mclk(mclk), .reset(reset), .tck(tck), .tms(tms), .trst_n(trst_n), .tdo(tdo),
	.tdo_oe(tdo_oe), .pad_oe(pad_oe), .instruction_select(instruction_select));

// ### tb/jtag_host.sv
`timescale 1ns/10ps
module jtag_host (
	input wire mclk,
	input wire tdo,
	output logic tck,
	output logic tms,
	output logic tdi
);
	logic seen;
	// Test clock parks low between frames; data idles high like a pull-up
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// One 80 ns period: change after the fall, sample serial out just before the rise
	task step(input logic t, input logic d);
		tms <= t;
		tdi <= d;
		repeat (8) @(posedge mclk);
		seen = tdo;
		tck <= 1'b1;
		repeat (8) @(posedge mclk);
		tck <= 1'b0;
	endtask
	// Mode select pattern, low bit first
	task walk(input logic [5:0] t, input int n);
		for (int i = 0; i < n; i++) begin
			step(t[i], 1'b1);
		end
	endtask
	// Shift n bits low first, leave on the last, then update and idle
	task shift(input int n, input logic [319:0] din, output logic [319:0] dout);
		dout = '0;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i]);
			dout[i] = seen;
		end
		walk(6'b000001, 2);
	endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/10ps
module tb;
	logic mclk, reset, trst_n;
	logic [280:0] pad_in, core_out;
	wire tck, tms, tdi, tdo, tdo_oe;
	wire [280:0] pad_out, pad_oe;
	wire [4:0] tap_state, instruction_select;
	int err_total, checked, cycles;
	// Bit 1 output, bit 3 bidirectional, bits 0 and 5 inputs
	boundary_scan_tap #(.OUT_MASK(281'h0a), .BIDIR_MASK(281'h08), .IN_MASK(281'h21)) i_dut (
		.mclk(mclk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
		.tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in), .core_out(core_out),
		.pad_out(pad_out), .pad_oe(pad_oe), .tap_state(tap_state),
		.instruction_select(instruction_select));
	jtag_host host (.mclk(mclk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
	task chk(input logic [319:0] seen, input logic [319:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task ir(input logic [4:0] code);
		logic [319:0] o;
		host.walk(6'b000011, 4);
		host.shift(5, code, o);
		chk(o[4:0], 5'h01);
		chk(instruction_select, code);
	endtask
	task dr(input int n, input logic [319:0] din, output logic [319:0] dout);
		host.walk(6'b000001, 3);
		host.shift(n, din, dout);
	endtask
	task t_idcode;
		logic [319:0] o;
		chk(instruction_select, 5'h02);
		host.walk(6'b000010, 4);
		host.shift(32, '1, o);
		chk(o[31:0], 32'h0000_0001);
		chk(tdo_oe, 1'b0);
		$display("idcode test done");
	endtask
	// Overlong shift shows capture, then the first bits in, unchanged, after 281
	task t_sample;
		logic [319:0] o;
		pad_in <= 281'h28;
		ir(5'h01);
		dr(290, 320'h2dab, o);
		chk(o[5], 1'b1);
		chk(o[3], 1'b1);
		chk(o[289:281], 9'h1ab);
		chk(pad_oe, 281'h0);
		$display("sample test done");
	endtask
	task t_extest;
		logic [319:0] o;
		ir(5'h00);
		chk(pad_out[1], 1'b1);
		chk(pad_oe[1], 1'b1);
		chk(pad_oe[3], 1'b1);
		chk(pad_out[3], 1'b0);
		dr(281, 320'h16, o);
		chk(o[3], 1'b1);
		chk(o[5], 1'b1);
		$display("extest test done");
	endtask
	// Float first, while extest still drives, then unknown codes and bypass
	task t_bypass;
		logic [4:0] codes [4] = '{5'h03, 5'h04, 5'h1e, 5'h1f};
		logic [319:0] o;
		foreach (codes[i]) begin
			ir(codes[i]);
			chk(pad_oe, 281'h0);
			dr(4, 320'h5, o);
			chk(o[3:0], 4'ha);
		end
		$display("bypass test done");
	endtask
	task t_trst;
		ir(5'h1f);
		host.walk(6'b000011, 4);
		host.walk(6'b011111, 5);
		chk(instruction_select, 5'h02);
		chk(tap_state, 5'h00);
		host.walk(6'b000000, 1);
		ir(5'h1f);
		host.walk(6'b000001, 3);
		trst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		chk(instruction_select, 5'h02);
		chk(tap_state, 5'h00);
		trst_n <= 1'b1;
		$display("reset test done");
	endtask
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// Guard against a hang; the full run needs about 12100 cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 60000) begin
			err_total++;
			finish_test;
		end
	end
	initial begin
		reset = 1'b1;
		trst_n = 1'b1;
		pad_in = 281'h0;
		core_out = 281'h0;
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		repeat (4) @(posedge mclk);
		t_idcode;
		t_sample;
		t_extest;
		t_bypass;
		t_trst;
		finish_test;
	end
endmodule
